// File: design/tx_buffer_command_checker.sv
// Transmit buffer command checker: parses command words, strips padding.
// Assumes an APB master writing one dword per transfer to the data port.
//
// Function
// - Start offset is bits 20:16 of the first word, 0 to 31.
// - Bit 13 of the first word marks the opening segment.
// - Bit 12 of the first word marks the closing segment.
// - Bits 10:0 of the first word give the buffer's payload length.
// - Start offset, buffer size and alignment give the padding dwords, which are dropped.
// - Sum buffer sizes per packet; mismatch with packet length flags error.
// - Offset and padding bytes never count toward the payload.
// - Tag in bits 31:16 of the second word goes into the status word.
// - Bit 13 of the second word suppresses the appended check sequence.
// - Two-bit alignment picks 4, 16 or 32 bytes; fourth code reserved.
// - Second word must match across a packet; mismatch flags error.
// - Low two offset bits pick the byte lane of the first byte.
`timescale 1ns/100ps
`include "tx_cmd_regs.svh"
module tx_buffer_command_checker (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output tx_cmd_pkg::beat_t outBeat,
    output logic             outValid,
    output logic             crcOff,
    output logic [31:0]      statusWord,
    output logic             statusValid,
    output logic             transmitErrorFlag,
    output logic             irq
);

    tx_cmd_pkg::parse_state_t state;
    tx_cmd_pkg::cmd_a_t        cmdA;
    tx_cmd_pkg::cmd_b_t        refB;
    logic [1:0]                ctrl;
    logic [`INT_WIDTH-1:0]     intSts;
    logic [`INT_WIDTH-1:0]     intMask;
    logic [15:0]               pktTotal;
    logic                      inPacket;
    logic                      pktErr;
    logic                      statusPending;
    logic [31:0]               lastStatus;
    logic [13:0]               pos;
    logic [13:0]               skipDw;
    logic [13:0]               dataDw;
    logic [13:0]               totalDw;

    logic                      setupPhase;
    logic                      accessDone;
    logic                      regWrite;
    logic                      dataWrite;
    logic                      addrHit;
    logic                      restart;
    tx_cmd_pkg::cmd_a_t        newA;
    tx_cmd_pkg::cmd_b_t        newB;
    logic [13:0]               newSkip;
    logic [13:0]               newData;
    logic [13:0]               newUsed;
    logic [13:0]               alignMask;
    logic [13:0]               newPad;
    logic                      alignBad;
    logic [15:0]               next_pktTotal;
    logic                      bMismatch;
    logic                      lenMismatch;
    logic                      noOpening;
    logic                      errEvent;
    logic                      doneEvent;
    logic                      bodyLast;
    logic                      inData;
    logic [10:0]               dataIdx;
    logic [3:0]                laneEn;
    logic [31:0]               next_rdata;
    logic [`INT_WIDTH-1:0]     next_intSts;
    logic [`INT_WIDTH-1:0]     setBits;
    logic [`INT_WIDTH-1:0]     clrBits;

    // APB phase decode; registers answer in the first cycle of the access phase
    assign setupPhase = psel && !penable;
    assign accessDone = psel && penable && pready;
    assign regWrite   = accessDone && pwrite;
    assign dataWrite  = regWrite && (paddr == `REG_DATA_PORT)
                      && ctrl[`CTRL_ENABLE];
    assign restart    = regWrite && (paddr == `REG_CTRL)
                      && pwdata[`CTRL_RESTART];

    // Known register addresses
    always_comb begin
        unique case (paddr)
            `REG_DATA_PORT,
            `REG_INT_STS,
            `REG_INT_MASK,
            `REG_CTRL,
            `REG_LAST_STATUS,
            `REG_PKT_STATE: addrHit = 1'b1;
            default:        addrHit = 1'b0;
        endcase
    end

    // Field views of the incoming dword
    assign newA = tx_cmd_pkg::cmd_a_t'(pwdata);
    assign newB = tx_cmd_pkg::cmd_b_t'(pwdata);

    // Whole dwords of leading offset, then dwords carrying payload
    assign newSkip = {11'h000, newA.startOffset[4:2]};
    assign newData = 14'((13'(newA.bufSize)
                   + 13'(newA.startOffset[1:0]) + 13'h0003) >> 2);
    assign newUsed = newSkip + newData;

    // Alignment mask in dwords; reserved code falls back to four bytes
    always_comb begin
        alignBad = 1'b0;
        unique case (newA.endAlign)
            `ALIGN_4:  alignMask = `MASK_ALIGN_4;
            `ALIGN_16: alignMask = `MASK_ALIGN_16;
            `ALIGN_32: alignMask = `MASK_ALIGN_32;
            default: begin
                alignMask = `MASK_ALIGN_4;
                alignBad  = 1'b1;
            end
        endcase
    end

    // Padding dwords needed to reach the alignment boundary
    assign newPad = (~newUsed + 14'h0001) & alignMask;

    // Running total and packet checks, judged at the second word
    always_comb begin
        if (cmdA.firstSeg) begin
            next_pktTotal = {5'h00, cmdA.bufSize};
        end else begin
            next_pktTotal = pktTotal + {5'h00, cmdA.bufSize};
        end
    end
    assign bMismatch   = !cmdA.firstSeg && inPacket
                       && (newB != refB);
    assign lenMismatch = cmdA.lastSeg
                       && (next_pktTotal != {5'h00, newB.pktLength});
    assign noOpening   = !cmdA.firstSeg && !inPacket;

    // Position tracking inside the buffer body
    assign bodyLast = (state == tx_cmd_pkg::BODY)
                    && (pos == totalDw - 14'h0001);
    assign inData   = (pos >= skipDw) && (pos < skipDw + dataDw);
    assign dataIdx  = 11'(pos - skipDw);

    tx_lane_mask uLaneMask (
        .dataIdx   (dataIdx),
        .leadBytes (cmdA.startOffset[1:0]),
        .bufSize   (cmdA.bufSize),
        .byteEn    (laneEn)
    );

    // Command parser; each data-port write advances it by one dword
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state   <= tx_cmd_pkg::WAIT_CMD_A;
            cmdA    <= '0;
            skipDw  <= 14'h0000;
            dataDw  <= 14'h0000;
            totalDw <= 14'h0000;
            pos     <= 14'h0000;
        end else if (restart) begin
            state <= tx_cmd_pkg::WAIT_CMD_A;
            pos   <= 14'h0000;
        end else if (dataWrite) begin
            unique case (state)
                tx_cmd_pkg::WAIT_CMD_A: begin
                    cmdA    <= newA;
                    skipDw  <= newSkip;
                    dataDw  <= newData;
                    totalDw <= newUsed + newPad;
                    state   <= tx_cmd_pkg::WAIT_CMD_B;
                end
                tx_cmd_pkg::WAIT_CMD_B: begin
                    pos <= 14'h0000;
                    if (totalDw == 14'h0000) begin
                        state <= tx_cmd_pkg::WAIT_CMD_A;
                    end else begin
                        state <= tx_cmd_pkg::BODY;
                    end
                end
                tx_cmd_pkg::BODY: begin
                    pos <= pos + 14'h0001;
                    if (bodyLast) begin
                        state <= tx_cmd_pkg::WAIT_CMD_A;
                    end
                end
            endcase
        end
    end

    // Packet bookkeeping at each accepted second word; alignment error at the first word
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            refB     <= '0;
            pktTotal <= 16'h0000;
            inPacket <= 1'b0;
            pktErr   <= 1'b0;
        end else if (restart) begin
            inPacket <= 1'b0;
            pktErr   <= 1'b0;
        end else if (dataWrite && state == tx_cmd_pkg::WAIT_CMD_B) begin
            pktTotal <= next_pktTotal;
            if (cmdA.firstSeg) begin
                refB <= newB;
            end
            // Opening first word already cleared it; errors pile up here
            pktErr   <= pktErr || errEvent;
            inPacket <= !cmdA.lastSeg;
        end else if (dataWrite && state == tx_cmd_pkg::WAIT_CMD_A) begin
            // Reserved alignment is judged as soon as the first word lands
            pktErr <= (pktErr && !newA.firstSeg) || alignBad;
        end
    end

    // Error and completion events for the sticky status bits
    assign errEvent  = (dataWrite && state == tx_cmd_pkg::WAIT_CMD_B
                       && (bMismatch || lenMismatch || noOpening))
                     || (dataWrite && state == tx_cmd_pkg::WAIT_CMD_A
                       && alignBad);
    assign doneEvent = statusPending && !statusValid
                     && (state == tx_cmd_pkg::WAIT_CMD_A);

    // Status word waits until the closing buffer body has drained
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            statusPending <= 1'b0;
            statusWord    <= 32'h00000000;
            statusValid   <= 1'b0;
            lastStatus    <= 32'h00000000;
            crcOff        <= 1'b0;
        end else begin
            statusValid <= 1'b0;
            if (dataWrite && state == tx_cmd_pkg::WAIT_CMD_B) begin
                crcOff <= newB.crcOff;
                if (cmdA.lastSeg) begin
                    statusPending <= 1'b1;
                    statusWord    <= {newB.tag, 16'h0000};
                    // Error bit gathers every fault of this packet
                    statusWord[`STATUS_ERR_BIT] <= pktErr || errEvent;
                end
            end else if (doneEvent) begin
                statusPending <= 1'b0;
                statusValid   <= 1'b1;
                lastStatus    <= statusWord;
            end
        end
    end

    // Payload beats; offset and padding dwords never leave the block
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            outBeat  <= '0;
            outValid <= 1'b0;
        end else begin
            outValid <= 1'b0;
            if (dataWrite && state == tx_cmd_pkg::BODY && inData) begin
                outValid       <= 1'b1;
                outBeat.data   <= pwdata;
                outBeat.byteEn <= laneEn;
                outBeat.first  <= cmdA.firstSeg && (pos == skipDw);
                outBeat.last   <= cmdA.lastSeg
                               && (pos == skipDw + dataDw - 14'h0001);
            end
        end
    end

    // Sticky interrupt bits; a new event wins over a same-cycle clear
    assign setBits = {doneEvent, errEvent};
    assign clrBits = (regWrite && paddr == `REG_INT_STS)
                   ? pwdata[`INT_WIDTH-1:0] : '0;
    assign next_intSts = (intSts & ~clrBits) | setBits;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            intSts            <= '0;
            transmitErrorFlag <= 1'b0;
            irq               <= 1'b0;
        end else begin
            intSts            <= next_intSts;
            transmitErrorFlag <= next_intSts[`INT_TX_ERROR];
            irq               <= |(next_intSts & intMask);
        end
    end

    // Software-written mask and control
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            intMask <= '0;
            ctrl    <= `CTRL_RESET;
        end else if (regWrite) begin
            if (paddr == `REG_INT_MASK) begin
                intMask <= pwdata[`INT_WIDTH-1:0];
            end
            if (paddr == `REG_CTRL) begin
                // Restart bit is a strobe and is not stored
                ctrl <= {1'b0, pwdata[`CTRL_ENABLE]};
            end
        end
    end

    // Read data is fetched during setup so it is stable in the access phase
    always_comb begin
        unique case (paddr)
            `REG_INT_STS:     next_rdata = {30'h00000000, intSts};
            `REG_INT_MASK:    next_rdata = {30'h00000000, intMask};
            `REG_CTRL:        next_rdata = {30'h00000000, ctrl};
            `REG_LAST_STATUS: next_rdata = lastStatus;
            `REG_PKT_STATE:   next_rdata = {12'h000, 1'b0, state,
                                            inPacket, pktTotal};
            default:          next_rdata = 32'h00000000;
        endcase
    end

    // APB answer: one wait-free access cycle after setup
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else if (setupPhase) begin
            pready  <= 1'b1;
            pslverr <= !addrHit;
            prdata  <= pwrite ? 32'h00000000 : next_rdata;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

endmodule

// File: design/tx_cmd_pkg.sv
// Types shared by the command checker, its bench and its port checks.
// Assumes nothing beyond a SystemVerilog compiler.
package tx_cmd_pkg;

    // First command word as the host writes it
    typedef struct packed {
        logic        irqOnDone;
        logic [4:0]  rsvdHigh;
        logic [1:0]  endAlign;
        logic [2:0]  rsvdMid;
        logic [4:0]  startOffset;
        logic [1:0]  rsvdLow;
        logic        firstSeg;
        logic        lastSeg;
        logic        rsvdBit;
        logic [10:0] bufSize;
    } cmd_a_t;

    // Second command word, identical across one packet
    typedef struct packed {
        logic [15:0] tag;
        logic [1:0]  rsvdHigh;
        logic        crcOff;
        logic        padOff;
        logic        rsvdBit;
        logic [10:0] pktLength;
    } cmd_b_t;

    // One payload beat handed to the transmit path
    typedef struct packed {
        logic [31:0] data;
        logic [3:0]  byteEn;
        logic        first;
        logic        last;
    } beat_t;

    typedef enum logic [1:0] {
        WAIT_CMD_A,
        WAIT_CMD_B,
        BODY
    } parse_state_t;

endpackage

// File: design/tx_cmd_regs.svh
// Offsets, field positions, reset values and codes for the command checker.
// Assumes inclusion by bare name; holds definitions only.
`ifndef TX_CMD_REGS_SVH
`define TX_CMD_REGS_SVH

// Register byte addresses on the APB port
`define REG_DATA_PORT    12'h000
`define REG_INT_STS      12'h004
`define REG_INT_MASK     12'h008
`define REG_CTRL         12'h00C
`define REG_LAST_STATUS  12'h010
`define REG_PKT_STATE    12'h014

// Interrupt status and mask bit positions
`define INT_TX_ERROR     0
`define INT_PKT_DONE     1
`define INT_WIDTH        2

// Control register bit positions and reset value
`define CTRL_ENABLE      0
`define CTRL_RESTART     1
`define CTRL_RESET       2'h1

// End-alignment codes and their dword masks
`define ALIGN_4          2'h0
`define ALIGN_16         2'h1
`define ALIGN_32         2'h2
`define ALIGN_RSVD       2'h3
`define MASK_ALIGN_4     14'h0000
`define MASK_ALIGN_16    14'h0003
`define MASK_ALIGN_32    14'h0007

// Status word error bit position
`define STATUS_ERR_BIT   15

`endif

// File: design/tx_lane_mask.sv
// Byte-lane enables for one payload dword of a transmit buffer.
// Assumes the caller gives the dword index inside the data region.
`timescale 1ns/100ps
module tx_lane_mask (
    input  wire logic [10:0] dataIdx,
    input  wire logic [1:0]  leadBytes,
    input  wire logic [10:0] bufSize,
    output logic      [3:0]  byteEn
);

    logic [12:0] spanEnd;

    // First byte past the payload, counted from the dword boundary
    assign spanEnd = {11'h000, leadBytes} + {2'h0, bufSize};

    // One comparator pair per lane
    for (genvar lane = 0; lane < 4; lane++) begin : gLane
        logic [12:0] bytePos;
        assign bytePos = {dataIdx, 2'(lane)};
        assign byteEn[lane] = (bytePos >= {11'h000, leadBytes})
                            && (bytePos < spanEnd);
    end

endmodule

// File: dv/tb.sv
// Self-checking bench for the transmit command checker.
// Assumes the host model drives APB and the checker is bound below.
`timescale 1ns/100ps
module tb;
    logic              clk;
    logic              rst;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [11:0]       paddr;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    tx_cmd_pkg::beat_t outBeat;
    logic              outValid;
    logic              crcOff;
    logic [31:0]       statusWord;
    logic              statusValid;
    logic              transmitErrorFlag;
    logic              irq;
    tx_cmd_pkg::beat_t beats[$];
    logic [31:0]       lastSts;
    int                badCount;
    int                checksDone;

    tx_buffer_command_checker dut_u (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .outBeat(outBeat), .outValid(outValid), .crcOff(crcOff),
        .statusWord(statusWord), .statusValid(statusValid),
        .transmitErrorFlag(transmitErrorFlag), .irq(irq));
    tx_host_model host_u (.clk(clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    initial clk = 1'h0;
    always #5 clk = ~clk;

    // Collect payload beats and the latest status word
    always @(posedge clk) begin
        if (outValid === 1'h1) beats.push_back(outBeat);
        if (statusValid === 1'h1) lastSts = statusWord;
    end

    task automatic chk(input logic [37:0] got, input logic [37:0] exp);
        checksDone++;
        if (got !== exp) begin
            badCount++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic giveVerdict();
        if (badCount == 0 && checksDone > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic t_regs();
        logic [31:0] d;
        logic        e;
        host_u.xfer(1'h0, 12'h00C, 32'h0, 1'h1, d, e);
        chk(38'(d), 38'h1);
        host_u.xfer(1'h0, 12'h008, 32'h0, 1'h1, d, e);
        chk(38'(d), 38'h0);
        host_u.xfer(1'h0, 12'h020, 32'h0, 1'h1, d, e);
        chk(38'(e), 38'h1);
    endtask

    task automatic t_single();
        beats.delete();
        host_u.send_buf(5'h00, 1'h1, 1'h1, 2'h0, 11'h004, 16'h1234, 1'h1,
                        11'h004);
        repeat (6) @(posedge clk);
        chk(38'(beats.size()), 38'h1);
        chk(beats[0], {32'h1111_1111, 4'hF, 1'h1, 1'h1});
        chk(38'(lastSts), 38'h1234_0000);
        chk(38'(crcOff), 38'h1);
    endtask

    // Lane 2 start after one skipped dword, padded to 32 bytes
    task automatic t_offset();
        beats.delete();
        host_u.send_buf(5'h06, 1'h1, 1'h1, 2'h2, 11'h005, 16'hBEEF, 1'h0,
                        11'h005);
        repeat (6) @(posedge clk);
        chk(38'(beats.size()), 38'h2);
        chk(beats[0], {32'h2222_2222, 4'hC, 1'h1, 1'h0});
        chk(beats[1], {32'h3333_3333, 4'h7, 1'h0, 1'h1});
        chk(38'(lastSts), 38'hBEEF_0000);
        chk(38'(crcOff), 38'h0);
    endtask

    // Two buffers whose sizes add up to the packet length
    task automatic t_frag();
        beats.delete();
        host_u.send_buf(5'h03, 1'h1, 1'h0, 2'h1, 11'h003, 16'h0042, 1'h0,
                        11'h006);
        host_u.send_buf(5'h00, 1'h0, 1'h1, 2'h0, 11'h003, 16'h0042, 1'h0,
                        11'h006);
        repeat (6) @(posedge clk);
        chk(38'(beats.size()), 38'h3);
        chk(beats[0], {32'h1111_1111, 4'h8, 1'h1, 1'h0});
        chk(beats[1], {32'h2222_2222, 4'h3, 1'h0, 1'h0});
        chk(beats[2], {32'h1111_1111, 4'h7, 1'h0, 1'h1});
        chk(38'(lastSts), 38'h0042_0000);
        chk(38'(transmitErrorFlag), 38'h0);
    endtask

    // Length mismatch, interrupt, clear, then differing second words
    task automatic t_err();
        host_u.send_buf(5'h00, 1'h1, 1'h1, 2'h0, 11'h004, 16'h0007, 1'h0,
                        11'h005);
        repeat (6) @(posedge clk);
        chk(38'(lastSts), 38'h0007_8000);
        chk(38'(irq), 38'h0);
        host_u.wr(12'h008, 32'h0000_0001);
        repeat (3) @(posedge clk);
        chk(38'(irq), 38'h1);
        host_u.wr(12'h004, 32'h0000_0003);
        repeat (3) @(posedge clk);
        chk(38'(transmitErrorFlag), 38'h0);
        chk(38'(irq), 38'h0);
        host_u.send_buf(5'h00, 1'h1, 1'h0, 2'h0, 11'h004, 16'h0001, 1'h0,
                        11'h008);
        host_u.send_buf(5'h00, 1'h0, 1'h1, 2'h0, 11'h004, 16'h0002, 1'h0,
                        11'h008);
        repeat (6) @(posedge clk);
        chk(38'(transmitErrorFlag), 38'h1);
        chk(38'(lastSts[15]), 38'h1);
        chk(38'(irq), 38'h1);
    endtask

    // Tag bits over the alignment field, then the reserved code
    task automatic t_fields();
        host_u.wr(12'h004, 32'h0000_0003);
        host_u.send_buf(5'h00, 1'h1, 1'h0, 2'h0, 11'h004, 16'h0300, 1'h0,
                        11'h008);
        host_u.send_buf(5'h00, 1'h0, 1'h1, 2'h0, 11'h004, 16'h0300, 1'h0,
                        11'h008);
        repeat (6) @(posedge clk);
        chk(38'(lastSts), 38'h0300_0000);
        chk(38'(transmitErrorFlag), 38'h0);
        host_u.send_buf(5'h00, 1'h1, 1'h1, 2'h3, 11'h004, 16'h0005, 1'h0,
                        11'h004);
        repeat (6) @(posedge clk);
        chk(38'(lastSts), 38'h0005_8000);
        chk(38'(transmitErrorFlag), 38'h1);
    endtask

    // Disabled data port, restart strobe, status and state reads
    task automatic t_ctrl();
        logic [31:0] d;
        logic        e;
        host_u.xfer(1'h0, 12'h010, 32'h0, 1'h1, d, e);
        chk(38'(d), 38'h0005_8000);
        host_u.wr(12'h00C, 32'h0000_0000);
        host_u.wr(12'h000, 32'h0000_3004);
        host_u.xfer(1'h0, 12'h014, 32'h0, 1'h1, d, e);
        chk(38'(d), 38'h0000_0004);
        host_u.wr(12'h00C, 32'h0000_0003);
        host_u.wr(12'h000, 32'h0000_3004);
        host_u.xfer(1'h0, 12'h014, 32'h0, 1'h1, d, e);
        chk(38'(d), 38'h0002_0004);
        host_u.wr(12'h00C, 32'h0000_0003);
        host_u.xfer(1'h0, 12'h014, 32'h0, 1'h1, d, e);
        chk(38'(d), 38'h0000_0004);
        host_u.xfer(1'h0, 12'h00C, 32'h0, 1'h1, d, e);
        chk(38'(d), 38'h1);
    endtask

    initial begin
        rst = 1'h1;
        badCount = 0;
        checksDone = 0;
        repeat (3) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        t_regs();
        t_single();
        t_offset();
        t_frag();
        t_err();
        t_fields();
        t_ctrl();
        giveVerdict();
    end

    // Hang guard, well beyond the roughly two hundred cycles the run needs
    initial begin
        #50000;
        badCount++;
        giveVerdict();
    end
endmodule

bind tx_buffer_command_checker tx_cmd_checker_asserts chk_u (.clk(clk),
    .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .outBeat(outBeat), .outValid(outValid), .crcOff(crcOff),
    .statusWord(statusWord), .statusValid(statusValid),
    .transmitErrorFlag(transmitErrorFlag));

// File: dv/tx_cmd_checker_asserts.sv
// Port-level checks on the transmit command checker.
// Assumes a bind to the top module; sees its ports only.
`timescale 1ns/100ps
module tx_cmd_checker_asserts (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       prdata,
    input  wire logic              pready,
    input  wire logic              pslverr,
    input  wire tx_cmd_pkg::beat_t outBeat,
    input  wire logic              outValid,
    input  wire logic              crcOff,
    input  wire logic [31:0]       statusWord,
    input  wire logic              statusValid,
    input  wire logic              transmitErrorFlag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Completed write into the data port
    logic dataWr;
    assign dataWr = psel && penable && pready && pwrite && paddr == 12'h000;

    property p_ready_one;
        psel && !penable |=> pready ##1 !pready;
    endproperty
    a_ready_one: assert property (p_ready_one) else $error("pready timing");
    property p_unmapped;
        pready && paddr > 12'h014 |-> pslverr;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("no slave error");
    property p_wr_rdata;
        pready && pwrite |-> prdata == 32'h0000_0000;
    endproperty
    a_wr_rdata: assert property (p_wr_rdata) else $error("rdata on write");
    property p_beat_cause;
        outValid |-> $past(dataWr) && outBeat.byteEn != 4'h0;
    endproperty
    a_beat_cause: assert property (p_beat_cause) else $error("stray beat");
    property p_beat_pulse;
        outValid |=> !outValid;
    endproperty
    a_beat_pulse: assert property (p_beat_pulse) else $error("beat width");
    property p_crc_cause;
        $changed(crcOff) |-> $past(dataWr);
    endproperty
    a_crc_cause: assert property (p_crc_cause) else $error("crcOff moved");
    property p_err_cause;
        $rose(transmitErrorFlag) |-> $past(dataWr);
    endproperty
    a_err_cause: assert property (p_err_cause) else $error("stray error");
    property p_sts_err;
        statusValid && statusWord[15] |-> transmitErrorFlag;
    endproperty
    a_sts_err: assert property (p_sts_err) else $error("error bit alone");
    property p_sts_pulse;
        statusValid |=> !statusValid [*2];
    endproperty
    a_sts_pulse: assert property (p_sts_pulse) else $error("status width");
endmodule

// File: dv/tx_host_model.sv
// Host side model: APB master that formats transmit buffers.
// Assumes callers start each sequence right after a rising edge.
`timescale 1ns/100ps
module tx_host_model (
    input  wire logic        clk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end

    // One transfer; chained ones keep psel up, released lines get scrambled
    task automatic xfer(input logic wr, input logic [11:0] a,
                        input logic [31:0] d, input logic fin,
                        output logic [31:0] rd, output logic err);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        if (fin) begin
            psel <= 1'h0;
            penable <= 1'h0;
            paddr <= ~a;
            pwdata <= ~d;
            @(posedge clk);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        err;
        xfer(1'h1, a, d, 1'h1, rd, err);
    endtask

    // Command words, skipped dwords, payload, then end padding
    task automatic send_buf(input logic [4:0] off, input logic fs,
                            input logic ls, input logic [1:0] al,
                            input logic [10:0] sz, input logic [15:0] tag,
                            input logic crc, input logic [10:0] len);
        int          n;
        int          u;
        logic [31:0] rd;
        logic        er;
        n = int'(off[4:2]) + (int'(off[1:0]) + int'(sz) + 3) / 4;
        u = (al == 2'h1) ? 4 : (al == 2'h2) ? 8 : 1;
        n = (n + u - 1) / u * u;
        xfer(1'h1, 12'h000, {1'h0, 5'h00, al, 3'h0, off, 2'h0, fs, ls, 1'h0,
             sz}, 1'h0, rd, er);
        xfer(1'h1, 12'h000, {tag, 2'h0, crc, 2'h0, len}, 1'(n == 0), rd,
             er);
        for (int i = 0; i < n; i++) begin
            xfer(1'h1, 12'h000, 32'(32'h1111_1111 * (i + 1)), 1'(i == n - 1),
                 rd, er);
        end
    endtask
endmodule
